// *** rtl/drsc_controller.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Function registers are 16 bits, packed in a 64-byte window, even offsets only.
// - All eight even offsets 0x0..0xE reach the one control word.
// - Offsets 0x10..0x2E map to sixteen sram words; first eight are channels.
// - Offsets 0x30..0x3F are reserved: read zero, writes ignored.
// - Window reachable through both the io base and the memory base.
// - Writing either function base updates the other as well.
// - First base points at sixteen 32-bit bridge operation registers.
// - Per channel: read word, load dac switches open, settle, close, settle, open, step.
// - Mux switches close one at a time, never two together.
// - Each per-channel refresh cycle lasts exactly 99.0 us.
// - Each refresh cycle starts with a 450 ns sram read.
// - Sram collisions stall the later requester until the first finishes.
// - Host sram access stalled past sixteen clocks gets a retry; master repeats it.
// - Refresh cycle length is unchanged by any sram collision.
// - One control bit closes all output switches; open after reset.
// - All sixteen 12-bit sram words are host writable and readable.
// - Uncontended host sram access takes about 330 ns.
// - Failure indicator lit by reset, turned off only by software.
// - Target only, with standard configuration space.
// - Control bit 11 turns failure indicator off; bit 10 selects two's complement.
module drsc_controller
  import drsc_pkg::*;
#(
  parameter int          REFRESH_CYCLES  = REFRESH_CYC,
  parameter int          MUX_OPEN_CYCLES = MUX_OPEN_CYC,
  parameter logic [15:0] VENDOR_ID       = 16'h1D00,  // arbitrary value
  parameter logic [15:0] DEVICE_ID       = 16'h0008,  // arbitrary value
  parameter logic [7:0]  REVISION_ID     = 8'h01      // arbitrary value
)(
  input  logic        clk,
  input  logic        reset,
  input  logic        frameN,
  input  logic        irdyN,
  input  logic        idsel,
  input  logic [3:0]  cbeN,
  input  logic [31:0] adIn,
  output logic [31:0] adOut,
  output logic        adOe,
  output logic        trdyN,
  output logic        devselN,
  output logic        stopN,
  output logic        targetOe,
  output logic [11:0] dacValue,
  output logic        dacLoad,
  output logic [7:0]  muxSelect,
  output logic        outputConnect,
  output logic        failureIndicator
);
  localparam logic [4:0] HOST_LAST = 5'(HOST_SRAM_CYC - 1);
  localparam int         HOST_LAT  = HOST_SRAM_CYC + 1;

  drsc_tgt_state_t state;
  drsc_dac_drive_t drive;
  logic [3:0]  cmd;
  logic [7:0]  offset;
  logic        tgtCfg;
  logic        tgtOps;
  logic        tgtFunc;
  logic        frameQ;
  logic [4:0]  latency;
  logic        hostAcc;
  logic [4:0]  accCnt;
  logic [15:0] control_status_word;
  logic [1:0]  cmdReg;
  logic [25:0] opsBase;
  logic [25:0] ioBase;
  logic [25:0] memBase;
  logic [31:0] opsReg [16];
  logic [11:0] sram [16];
  logic [2:0]  channel;
  logic        seqReq;
  logic        seqGrant;

  logic        addrPhase;
  logic        cfgHit;
  logic        ioHit;
  logic        memFnHit;
  logic        opsHit;
  logic        isWrite;
  logic [3:0]  dw;
  logic        needSram;
  logic        dataOk;
  logic        accDone;
  logic        ready;
  logic        hostWants;
  logic        hostGrant;
  logic        retryNow;
  logic        xfer;
  logic        wrXfer;
  logic        csrWr;
  logic [15:0] csrNew;
  logic        failOffNew;
  logic        barWr;
  logic [31:0] barMerged;
  logic [25:0] barNew;
  logic [2:0]  sramDw;
  logic [1:0][11:0] sramMerged;
  logic [31:0] readData;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] beN);
    logic [15:0] r;
    r = old;
    for (int i = 0; i < 2; i++)
      if (!beN[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction : merge16

  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] beN);
    return {merge16(old[31:16], nw[31:16], beN[3:2]), merge16(old[15:0], nw[15:0], beN[1:0])};
  endfunction : merge32

  // one 16-bit register per even offset, upper half sits in lanes 3:2
  function automatic logic [15:0] halfRead(input logic [4:0] h);
    logic [3:0] idx;
    idx = 4'(h - SRAM_OFFSET[5:1]);
    if (h < SRAM_OFFSET[5:1])
      return (control_status_word & CSR_WR_MASK) | {13'h0, channel};
    else if (h < RSVD_OFFSET[5:1])
      return {4'h0, sram[idx]};
    else
      return 16'h0000;
  endfunction : halfRead

  // address decode, bus pins share our clock so no synchroniser
  always_comb begin
    addrPhase = !frameN && frameQ && state == TGT_IDLE;
    cfgHit    = (cbeN == CMD_CFG_RD || cbeN == CMD_CFG_WR) && idsel && adIn[1:0] == 2'b00;
    ioHit     = (cbeN == CMD_IO_RD || cbeN == CMD_IO_WR) && cmdReg[0] &&
                adIn[31:6] == ioBase;
    memFnHit  = (cbeN == CMD_MEM_RD || cbeN == CMD_MEM_WR) && cmdReg[1] &&
                adIn[31:6] == memBase;
    opsHit    = (cbeN == CMD_MEM_RD || cbeN == CMD_MEM_WR) && cmdReg[1] &&
                adIn[31:6] == opsBase && !memFnHit;
  end

  assign isWrite   = cmd[0];
  assign dw        = offset[5:2];
  assign needSram  = tgtFunc && dw >= SRAM_OFFSET[5:2] && dw < RSVD_OFFSET[5:2];
  assign sramDw    = 3'(dw - SRAM_OFFSET[5:2]);
  assign dataOk    = !isWrite || !irdyN;
  assign accDone   = hostAcc && accCnt == HOST_LAST;
  assign ready     = needSram ? accDone : dataOk;
  // refresh wins a tie so its fixed schedule keeps its read slot
  // no grant in the retry cycle, so no access is left running without its master
  assign hostWants = state == TGT_CLAIM && needSram && dataOk && !hostAcc &&
                     latency != RETRY_LIMIT - 5'h1;
  assign seqGrant  = seqReq && !hostAcc;
  assign hostGrant = hostWants && !seqReq;
  assign retryNow  = state == TGT_CLAIM && !hostAcc && !ready &&
                     latency == RETRY_LIMIT - 5'h1;
  assign xfer      = state == TGT_DATA && !irdyN;
  assign wrXfer    = xfer && isWrite;

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      frameQ <= 1'b1;
    else
      frameQ <= frameN;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd     <= 4'h0;
      offset  <= 8'h00;
      tgtCfg  <= 1'b0;
      tgtOps  <= 1'b0;
      tgtFunc <= 1'b0;
    end else if (addrPhase) begin
      cmd     <= cbeN;
      offset  <= adIn[7:0];
      tgtCfg  <= cfgHit;
      tgtOps  <= opsHit;
      tgtFunc <= ioHit || memFnHit;
    end
  end

  // single data phase per access: data goes out with a disconnect
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      state <= TGT_IDLE;
    else begin
      case (state)
        TGT_IDLE:
          if (addrPhase && (cfgHit || ioHit || memFnHit || opsHit))
            state <= TGT_CLAIM;
        TGT_CLAIM:
          if (retryNow)
            state <= TGT_STOPWAIT;
          else if (ready)
            state <= TGT_DATA;
        TGT_DATA:
          if (!irdyN)
            state <= frameN ? TGT_TURN : TGT_STOPWAIT;
        TGT_STOPWAIT:
          if (frameN)
            state <= TGT_TURN;
        TGT_TURN:
          state <= TGT_IDLE;
        default:
          state <= TGT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      latency <= 5'h0;
    else if (addrPhase)
      latency <= 5'h1;
    else if (state == TGT_CLAIM)
      latency <= latency + 5'h1;
  end

  // a started access always finishes; only a wait for the grant is retried
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hostAcc <= 1'b0;
      accCnt  <= 5'h0;
    end else if (hostGrant) begin
      hostAcc <= 1'b1;
      accCnt  <= 5'h0;
    end else if (accDone)
      hostAcc <= 1'b0;
    else if (hostAcc)
      accCnt <= accCnt + 5'h1;
  end

  always_comb begin
    readData = 32'h0;
    if (tgtFunc)
      readData = {halfRead({dw, 1'b1}), halfRead({dw, 1'b0})};
    else if (tgtOps)
      readData = opsReg[dw];
    else begin
      case (offset[7:2])
        CFG_ID_IDX:    readData = {DEVICE_ID, VENDOR_ID};
        CFG_CMD_IDX:   readData = {30'h0, cmdReg};
        CFG_CLASS_IDX: readData = {CLASS_CODE, REVISION_ID};
        CFG_BAR0_IDX:  readData = {opsBase, 6'h00};
        CFG_BAR1_IDX:  readData = {ioBase, BAR_IO_FLAG};
        CFG_BAR2_IDX:  readData = {memBase, 6'h00};
        default:       readData = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      adOut <= 32'h0;
    else if (state == TGT_CLAIM && ready)
      adOut <= readData;
  end

  assign adOe     = state == TGT_DATA && !isWrite;
  assign trdyN    = state != TGT_DATA;
  assign devselN  = !(state == TGT_CLAIM || state == TGT_DATA || state == TGT_STOPWAIT);
  assign stopN    = !(state == TGT_DATA || state == TGT_STOPWAIT);
  assign targetOe = state != TGT_IDLE;

  // control word write: the upper half wins when both halves are enabled
  assign csrWr      = wrXfer && tgtFunc && dw < SRAM_OFFSET[5:2];
  assign csrNew     = ((cbeN[3:2] != 2'b11) ? merge16(control_status_word, adIn[31:16], cbeN[3:2])
                                            : merge16(control_status_word, adIn[15:0], cbeN[1:0])) & CSR_WR_MASK;
  assign failOffNew = csrNew[CSR_FAILOFF_BIT];

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      control_status_word <= CSR_RESET;
    else if (csrWr)
      control_status_word <= csrNew;
  end

  assign outputConnect    = control_status_word[CSR_CONNECT_BIT];
  assign failureIndicator = !control_status_word[CSR_FAILOFF_BIT];

  always_comb begin
    for (int j = 0; j < 2; j++)
      sramMerged[j] = 12'(merge16({4'h0, sram[{sramDw, j[0]}]}, adIn[16*j +: 16],
                                  cbeN[2*j +: 2]));
  end

  // sram holds data only, so it has no reset
  always_ff @(posedge clk) begin
    for (int j = 0; j < 2; j++)
      if (wrXfer && needSram && cbeN[2*j +: 2] != 2'b11)
        sram[{sramDw, j[0]}] <= sramMerged[j];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < 16; k++)
        opsReg[k] <= 32'h0;
    end else if (wrXfer && tgtOps)
      opsReg[dw] <= merge32(opsReg[dw], adIn, cbeN);
  end

  assign barWr     = wrXfer && tgtCfg && (offset[7:2] == CFG_BAR1_IDX ||
                                          offset[7:2] == CFG_BAR2_IDX);
  assign barMerged = merge32({ioBase, 6'h00}, adIn, cbeN);
  assign barNew    = barMerged[31:6];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmdReg  <= 2'b00;
      opsBase <= 26'h0;
      ioBase  <= 26'h0;
      memBase <= 26'h0;
    end else if (wrXfer && tgtCfg) begin
      if (offset[7:2] == CFG_CMD_IDX && !cbeN[0])
        cmdReg <= adIn[1:0];
      if (offset[7:2] == CFG_BAR0_IDX)
        opsBase <= 26'(merge32({opsBase, 6'h00}, adIn, cbeN) >> 6);
      if (barWr) begin
        ioBase  <= barNew;
        memBase <= barNew;
      end
    end
  end

  drsc_refresh_seq #(
    .REFRESH_CYCLES  (REFRESH_CYCLES),
    .MUX_OPEN_CYCLES (MUX_OPEN_CYCLES)
  ) u_seq (
    .clk       (clk),
    .reset     (reset),
    .twosComp  (control_status_word[CSR_TWOS_BIT]),
    .readGrant (seqGrant),
    .sramWord  (sram[{1'b0, channel}]),
    .readReq   (seqReq),
    .channel   (channel),
    .drive     (drive)
  );

  assign dacValue  = drive.value;
  assign dacLoad   = drive.load;
  assign muxSelect = drive.muxSel;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_host_start;
    hostGrant;
  endsequence

  a_bar_mirror: assert property (barWr |=> ioBase == memBase && ioBase == $past(barNew))
    else $error("function bases not mirrored");
  a_retry_point: assert property ((state == TGT_STOPWAIT && $past(state) == TGT_CLAIM)
                                  |-> latency == RETRY_LIMIT && trdyN)
    else $error("retry issued at wrong latency");
  a_arb_exclusive: assert property (hostAcc |-> !seqGrant && !hostGrant)
    else $error("sram granted twice");
  a_host_access: assert property (s_host_start |-> ##HOST_LAT state == TGT_DATA)
    else $error("host sram access time wrong");
  a_fail_write: assert property (csrWr |=> failureIndicator == !$past(failOffNew))
    else $error("failure indicator did not follow write");
  a_connect_hold: assert property (!csrWr |=> $stable(outputConnect))
    else $error("output switches moved without a write");
endmodule : drsc_controller

// *** rtl/drsc_pkg.sv ***
package drsc_pkg;
  // clock and refresh timing
  localparam int CLK_PERIOD_NS     = 20;
  localparam int REFRESH_PERIOD_NS = 99000;
  localparam int REFRESH_CYC       = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SEQ_READ_NS       = 450;
  localparam int SEQ_READ_CYC      = (SEQ_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_SRAM_NS      = 330;
  localparam int HOST_SRAM_CYC     = HOST_SRAM_NS / CLK_PERIOD_NS;
  localparam int DAC_LOAD_NS       = 1000;
  localparam int DAC_LOAD_CYC      = DAC_LOAD_NS / CLK_PERIOD_NS;
  localparam int MUX_CLOSE_NS      = 49500;
  localparam int MUX_CLOSE_CYC     = MUX_CLOSE_NS / CLK_PERIOD_NS;
  localparam int MUX_OPEN_NS       = 98000;
  localparam int MUX_OPEN_CYC      = MUX_OPEN_NS / CLK_PERIOD_NS;
  localparam logic [4:0] RETRY_LIMIT = 5'h10;

  // function window layout, byte offsets
  localparam logic [5:0] SRAM_OFFSET = 6'h10;
  localparam logic [5:0] RSVD_OFFSET = 6'h30;

  // control and status word
  localparam logic [15:0] CSR_RESET       = 16'h0000;
  localparam logic [15:0] CSR_WR_MASK     = 16'h0D00;
  localparam int          CSR_CONNECT_BIT = 8;
  localparam int          CSR_TWOS_BIT    = 10;
  localparam int          CSR_FAILOFF_BIT = 11;

  // bus commands
  localparam logic [3:0] CMD_IO_RD  = 4'h2;
  localparam logic [3:0] CMD_IO_WR  = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;

  // configuration dword indices
  localparam logic [5:0]  CFG_ID_IDX    = 6'h00;
  localparam logic [5:0]  CFG_CMD_IDX   = 6'h01;
  localparam logic [5:0]  CFG_CLASS_IDX = 6'h02;
  localparam logic [5:0]  CFG_BAR0_IDX  = 6'h04;
  localparam logic [5:0]  CFG_BAR1_IDX  = 6'h05;
  localparam logic [5:0]  CFG_BAR2_IDX  = 6'h06;
  localparam logic [23:0] CLASS_CODE    = 24'h0000FF;
  localparam logic [5:0]  BAR_IO_FLAG   = 6'h01;

  typedef struct packed {
    logic [11:0] value;
    logic        load;
    logic [7:0]  muxSel;
  } drsc_dac_drive_t;

  typedef enum logic [2:0] {
    TGT_IDLE     = 3'b000,
    TGT_CLAIM    = 3'b001,
    TGT_DATA     = 3'b010,
    TGT_STOPWAIT = 3'b011,
    TGT_TURN     = 3'b100
  } drsc_tgt_state_t;
endpackage : drsc_pkg

// *** rtl/drsc_refresh_seq.sv ***
`timescale 1ns/100ps
module drsc_refresh_seq
  import drsc_pkg::*;
#(
  parameter int REFRESH_CYCLES  = REFRESH_CYC,
  parameter int MUX_OPEN_CYCLES = MUX_OPEN_CYC
)(
  input  logic            clk,
  input  logic            reset,
  input  logic            twosComp,
  input  logic            readGrant,
  input  logic [11:0]     sramWord,
  output logic            readReq,
  output logic [2:0]      channel,
  output drsc_dac_drive_t drive
);
  localparam logic [12:0] LAST_CYCLE = 13'(REFRESH_CYCLES - 1);
  localparam logic [12:0] OPEN_AT    = 13'(MUX_OPEN_CYCLES);
  localparam logic [12:0] CLOSE_AT   = 13'(MUX_CLOSE_CYC);
  localparam logic [12:0] LOAD_AT    = 13'(DAC_LOAD_CYC);
  localparam int          RD_REST    = SEQ_READ_CYC - 7;

  logic [12:0] cycleCnt;
  logic [4:0]  readCnt;
  logic        pending;
  logic        reading;
  logic        readLast;
  logic [11:0] sample;
  logic [2:0]  chanQ;
  logic [12:0] periodCnt;

  assign readReq  = pending | reading;
  assign readLast = reading && readCnt == 5'(SEQ_READ_CYC - 1);

  // period counter never waits on the sram, so collisions do not stretch it
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      cycleCnt <= 13'h0;
    else if (cycleCnt == LAST_CYCLE)
      cycleCnt <= 13'h0;
    else
      cycleCnt <= cycleCnt + 13'h1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      channel <= 3'h0;
    else if (cycleCnt == LAST_CYCLE)
      channel <= channel + 3'h1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pending <= 1'b0;
      reading <= 1'b0;
      readCnt <= 5'h0;
      sample  <= 12'h000;
    end else begin
      if (cycleCnt == 13'h0 && !reading)
        pending <= 1'b1;
      else if (readGrant)
        pending <= 1'b0;
      if (pending && readGrant) begin
        reading <= 1'b1;
        readCnt <= 5'h0;
      end else if (readLast) begin
        reading <= 1'b0;
        sample  <= sramWord;
      end else if (reading)
        readCnt <= readCnt + 5'h1;
    end
  end

  // load lands well after the longest stalled read, switches all open
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      drive <= '0;
    else begin
      drive.load <= (cycleCnt == LOAD_AT);
      if (cycleCnt == LOAD_AT)
        drive.value <= twosComp ? {~sample[11], sample[10:0]} : sample;
      if (cycleCnt >= CLOSE_AT && cycleCnt < OPEN_AT)
        drive.muxSel <= 8'(8'h01 << channel);
      else
        drive.muxSel <= 8'h00;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chanQ     <= 3'h0;
      periodCnt <= 13'h0;
    end else begin
      chanQ     <= channel;
      periodCnt <= (channel != chanQ) ? 13'h1 : periodCnt + 13'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_read_start;
    pending && readGrant;
  endsequence
  sequence s_read_hold;
    reading [*8] ##RD_REST !reading;
  endsequence

  a_mux_one_hot: assert property ($onehot0(drive.muxSel))
    else $error("two mux switches closed together");
  a_load_mux_open: assert property (drive.load |-> drive.muxSel == 8'h00)
    else $error("dac loaded while a mux switch is closed");
  a_read_hold: assert property (s_read_start |=> s_read_hold)
    else $error("sram read not held for its full time");
  a_channel_step: assert property ((channel != chanQ) |-> channel == 3'(chanQ + 3'h1))
    else $error("channel counter did not step by one");
  a_refresh_period: assert property ((channel != chanQ) |->
                                     periodCnt == LAST_CYCLE + 13'h1)
    else $error("refresh cycle length wrong");
endmodule : drsc_refresh_seq

// *** test/drsc_controller_test.sv ***
`timescale 1ns/100ps
module drsc_controller_test;
  import drsc_pkg::*;
  localparam int          RC  = 4950;
  localparam logic [31:0] IOB = 32'h0000_4000;
  localparam logic [31:0] OPB = 32'h0001_0000;
  logic        clk;
  logic        reset;
  logic        frameN;
  logic        irdyN;
  logic        idsel;
  logic [3:0]  cbeN;
  logic [31:0] adIn;
  logic [31:0] adOut;
  logic        trdyN;
  logic        devselN;
  logic        stopN;
  logic [11:0] dacValue;
  logic        dacLoad;
  logic [7:0]  muxSelect;
  logic [7:0]  prevMux;
  logic        outputConnect;
  logic        failureIndicator;
  logic        adOe;
  logic        targetOe;
  logic        curRead;
  logic [31:0] lfsrState;
  logic [31:0] rd;
  logic [31:0] v;
  logic        ok;
  logic [15:0] csrM;
  int          sramM[16];
  int          n_errors;
  int          total_checks;
  int          cyc;
  int          pulses;
  int          lastPulse;
  int          checkFrom;
  int          w;

  drsc_controller #(.REFRESH_CYCLES(RC), .MUX_OPEN_CYCLES(4900)) DUT (
    .clk(clk), .reset(reset), .frameN(frameN), .irdyN(irdyN), .idsel(idsel), .cbeN(cbeN),
    .adIn(adIn), .adOut(adOut), .adOe(adOe), .trdyN(trdyN), .devselN(devselN), .stopN(stopN),
    .targetOe(targetOe), .dacValue(dacValue), .dacLoad(dacLoad), .muxSelect(muxSelect),
    .outputConnect(outputConnect), .failureIndicator(failureIndicator));

  drsc_host_model host (
    .clk(clk), .adOut(adOut), .trdyN(trdyN), .devselN(devselN), .stopN(stopN),
    .frameN(frameN), .irdyN(irdyN), .idsel(idsel), .cbeN(cbeN), .adIn(adIn));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    return lfsrState;
  endfunction : rnd

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task acc(input logic [3:0] cmd, input logic [31:0] addr, input logic [3:0] be,
           input logic [31:0] wd);
    curRead = !cmd[0];
    host.xfer(cmd, addr, be, wd, rd, ok);
  endtask : acc

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // refresh monitor; one dac load per channel period
  always @(posedge clk) begin
    cyc++;
    if (trdyN === 1'b0) check("ad drive", {targetOe, adOe}, {1'b1, curRead});
    if (dacLoad === 1'b1) begin
      check("mux at load", muxSelect, 32'h0);
      if (pulses > 0) check("period", cyc - lastPulse, RC);
      if (pulses >= checkFrom)
        check("dac", dacValue, sramM[pulses % 8] ^ (csrM[10] ? 32'h800 : 32'h0));
      lastPulse = cyc;
      pulses++;
    end
    if (muxSelect !== 8'h00 && prevMux === 8'h00)
      check("mux", muxSelect, 8'h01 << ((pulses - 1) % 8));
    prevMux = muxSelect;
    // timeout last, so nothing runs after the close
    if (cyc > 70000) begin
      n_errors++;
      close_out;
    end
  end

  initial begin
    reset = 1'b1;
    n_errors = 0;
    total_checks = 0;
    cyc = 0;
    pulses = 0;
    checkFrom = 1000;
    prevMux = 8'h00;
    lfsrState = 32'h9446;
    csrM = 16'h0000;
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    check("failure_indicator", failureIndicator, 32'h1);
    check("connect", outputConnect, 32'h0);
    acc(CMD_CFG_WR, 32'h04, 4'h0, 32'h3);
    acc(CMD_CFG_WR, 32'h14, 4'h0, IOB);
    acc(CMD_CFG_RD, 32'h18, 4'h0, 32'h0);
    check("bar2", rd & 32'hFFFF_FFC0, IOB);
    acc(CMD_CFG_WR, 32'h10, 4'h0, OPB);
    v = rnd();
    acc(CMD_MEM_WR, OPB + 32'h8, 4'h0, v);
    acc(CMD_MEM_RD, OPB + 32'h8, 4'h0, 32'h0);
    check("ops reg", rd, v);
    $display("config test done");
    for (int d = 0; d < 8; d++) begin
      v = rnd();
      acc(d[0] ? CMD_MEM_WR : CMD_IO_WR, IOB + 32'h10 + 4 * d, 4'h0, v);
      sramM[2 * d] = v[11:0];
      sramM[2 * d + 1] = v[27:16];
    end
    for (int d = 0; d < 8; d++) begin
      acc(d[0] ? CMD_IO_RD : CMD_MEM_RD, IOB + 32'h10 + 4 * d, 4'h0, 32'h0);
      check("sram", rd, (sramM[2 * d + 1] << 16) | sramM[2 * d]);
    end
    acc(CMD_IO_WR, IOB + 32'h30, 4'h0, 32'hFFFF_FFFF);
    acc(CMD_IO_RD, IOB + 32'h30, 4'h0, 32'h0);
    check("reserved", rd, 32'h0);
    acc(CMD_MEM_RD, 32'h8000_0000, 4'h0, 32'h0);
    check("unmapped", ok, 32'h0);
    $display("window test done");
    acc(CMD_IO_WR, IOB + 32'h4, 4'b0011, 32'h0D00_0000);
    csrM = 16'h0D00;
    acc(CMD_MEM_RD, IOB + 32'hC, 4'h0, 32'h0);
    check("csr", rd & 32'hFFF8_FFF8, 32'h0D00_0D00);
    check("failure_indicator", failureIndicator, 32'h0);
    check("connect", outputConnect, 32'h1);
    checkFrom = pulses + 2;
    $display("control test done");
    // back-to-back host reads so some collide with refresh reads
    while (pulses < 11) begin
      // word index held, pulses may step during the access
      w = pulses % 8;
      acc(CMD_IO_RD, IOB + 32'h10 + 4 * w, 4'h0, 32'h0);
      check("busy sram ok", ok, 32'h1);
      check("busy sram", rd, (sramM[2 * w + 1] << 16) | sramM[2 * w]);
    end
    $display("refresh test done");
    close_out;
  end
endmodule : drsc_controller_test

// *** test/drsc_host_model.sv ***
`timescale 1ns/100ps
module drsc_host_model
  import drsc_pkg::*;
(
  input  logic        clk,
  input  logic [31:0] adOut,
  input  logic        trdyN,
  input  logic        devselN,
  input  logic        stopN,
  output logic        frameN,
  output logic        irdyN,
  output logic        idsel,
  output logic [3:0]  cbeN,
  output logic [31:0] adIn
);
  initial begin
    frameN = 1'b1;
    irdyN  = 1'b1;
    idsel  = 1'b0;
    cbeN   = 4'hF;
    adIn   = 32'h0;
  end

  // single data phase; requests held until trdy or stop is sampled low
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0;
    for (int t = 0; t < 8 && !ok; t++) begin
      @(posedge clk);
      #1;
      frameN = 1'b0;
      cbeN   = cmd;
      adIn   = addr;
      idsel  = (cmd == CMD_CFG_RD) || (cmd == CMD_CFG_WR);
      @(posedge clk);
      #1;
      frameN = 1'b1;
      irdyN  = 1'b0;
      cbeN   = be;
      idsel  = 1'b0;
      adIn   = cmd[0] ? wd : ~addr;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (trdyN !== 1'b0 && stopN !== 1'b0 && n < 40);
      if (trdyN === 1'b0) begin
        rd = adOut;
        ok = 1'b1;
      end else if (devselN !== 1'b0) begin
        t = 8;
      end
      #1;
      irdyN = 1'b1;
      cbeN  = ~cbeN;
      adIn  = ~adIn;
      // turnaround cycle must pass before the next frame
      repeat (2) @(posedge clk);
    end
  endtask : xfer
endmodule : drsc_host_model
